// ===== fpu_status_and_opcode_decode.sv
/*
 * Floating-point status word, exception recording and instruction
 * decode for a slave arithmetic coprocessor.
 * Assumes one instruction at a time, one done_i pulse per accepted
 * instruction with its conditions, and every strobe on mclk_i.
 */
// Functional notes
// - Rounding select sits in bits 8:7; code 0 is nearest, ties to even.
// - Codes 1, 2, 3 select toward zero, toward plus, toward minus.
// - Underflow traps only when enabled; else result forced to plus zero.
// - Inexact traps only when enabled; else rounded result is delivered.
// - Trap cause goes to zero on clean completion, reset or zero load.
// - Underflow and inexact codes are recorded regardless of enables.
// - Code 2 marks overflow, including overflow from rounding.
// - Code 3 marks nonzero divided by zero; zero by zero excluded.
// - Unsupported encodings are detected and recorded as code 4.
// - Code 5 marks reserved operands or zero divided by zero.
// - Inexact with another exception keeps other code, inexact flag kept.
// - Cause code 7 is never produced.
// - Underflow flag bit 4 sets on every underflow; clears by load.
// - Inexact flag bit 6 sets on clean inexact results; clears by load.
// - Register written flag bit 16 sets on data register writes of untrapped instructions.
// - Software field bits 15:9 hold whatever the load wrote.
// - Integer size field decodes 0 byte, 1 word, 3 double word.
// - Precision bit 1 means single, 0 means double.
// - Format 9 op codes decode the conversion moves.
// - Format 11 op codes decode the arithmetic operations.
// - Format 12 codes 4 and 5 decode exponent scale and extract.
// - Only underflow and inexact traps can be masked.
// - Reset clears the whole status word.
`timescale 1ns/1ps
`default_nettype none

module fpu_status_and_opcode_decode
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic instr_valid_i,
    input wire logic [1:0] format_i,
    input wire logic [3:0] op_i,
    input wire logic [1:0] int_size_i,
    input wire logic precision_i,
    input wire logic done_i,
    input wire logic underflow_i,
    input wire logic overflow_i,
    input wire logic div_by_zero_i,
    input wire logic reserved_operand_i,
    input wire logic zero_by_zero_i,
    input wire logic inexact_i,
    input wire logic reg_write_i,
    input wire logic load_status_i,
    input wire logic [31:0] load_data_i,
    input wire logic store_status_i,
    output logic [31:0] status_o,
    output logic [31:0] store_data_o,
    output logic store_valid_o,
    output fpu_status_pkg::round_mode_t rounding_select_o,
    output logic trap_o,
    output logic zero_result_o,
    output logic deliver_rounded_o,
    output fpu_status_pkg::op_kind_t op_kind_o,
    output logic [2:0] int_bytes_o,
    output logic single_o,
    output logic busy_o
);
    import fpu_status_pkg::*;

    logic [1:0] rst_sync;
    wire rst_n = rst_sync[1];

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    ctl_state_t state;
    ctl_state_t next_state;

    op_kind_t dec_kind;
    logic [2:0] dec_bytes;
    logic dec_single;
    logic dec_illegal;

    fpu_opcode_decoder u_decoder
    (
        .format_i(format_i),
        .op_i(op_i),
        .int_size_i(int_size_i),
        .precision_i(precision_i),
        .op_kind_o(dec_kind),
        .int_bytes_o(dec_bytes),
        .single_o(dec_single),
        .illegal_o(dec_illegal)
    );

    // Status load and store never go busy
    wire idle = (state == ST_IDLE);
    wire accept = idle && instr_valid_i;
    wire accept_illegal = accept && dec_illegal;
    wire is_status_cmd = (dec_kind == OP_LOAD_STATUS)
        || (dec_kind == OP_STORE_STATUS);
    wire accept_exec = accept && !dec_illegal && !is_status_cmd;
    wire finish = (state == ST_BUSY) && done_i;
    wire ev_valid = accept_illegal || finish;

    wire is_divide = (op_kind_o == OP_DIVIDE);
    wire ev_invalid = finish
        && (reserved_operand_i || (is_divide && zero_by_zero_i));
    wire ev_div_zero = finish && is_divide && div_by_zero_i
        && !zero_by_zero_i;
    wire ev_overflow = finish && overflow_i;
    wire ev_underflow = finish && underflow_i;
    wire ev_inexact = finish && inexact_i;

    logic [2:0] ev_cause;
    logic ev_other;
    logic ev_trap;

    fpu_trap_cause_encoder u_cause
    (
        .illegal_i(accept_illegal),
        .invalid_i(ev_invalid),
        .div_zero_i(ev_div_zero),
        .overflow_i(ev_overflow),
        .underflow_i(ev_underflow),
        .inexact_i(ev_inexact),
        .underflow_en_i(status_o[UNDERFLOW_EN_BIT]),
        .inexact_en_i(status_o[INEXACT_EN_BIT]),
        .cause_o(ev_cause),
        .other_error_o(ev_other),
        .trap_o(ev_trap)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (accept_exec)
                    next_state = ST_BUSY;
            ST_BUSY:
                if (done_i)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // A load replaces the current word
    wire [31:0] load_word = load_data_i & STATUS_LIVE_MASK;
    wire [31:0] base = load_status_i ? load_word : status_o;

    // Hardware sets win over a load in the same cycle
    wire set_under = ev_underflow;
    wire set_if = ev_inexact && !ev_other;
    wire set_rw = finish && reg_write_i && !ev_trap;
    wire [2:0] next_cause = ev_valid ? ev_cause
        : base[TRAP_CAUSE_LSB +: TRAP_CAUSE_W];

    logic [31:0] next_status;

    always_comb
    begin
        next_status = base;
        next_status[TRAP_CAUSE_LSB +: TRAP_CAUSE_W] = next_cause;
        next_status[UNDERFLOW_FLAG_BIT] = base[UNDERFLOW_FLAG_BIT] | set_under;
        next_status[INEXACT_FLAG_BIT] = base[INEXACT_FLAG_BIT] | set_if;
        next_status[REG_WRITTEN_BIT] = base[REG_WRITTEN_BIT] | set_rw;
    end

    wire next_zero = ev_underflow && !status_o[UNDERFLOW_EN_BIT];
    wire next_deliver = set_if && !status_o[INEXACT_EN_BIT];
    wire [1:0] next_round = next_status[ROUND_LSB +: ROUND_W];

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            status_o <= STATUS_RESET;
            rounding_select_o <= ROUND_NEAREST;
        end
        else
        begin
            state <= next_state;
            status_o <= next_status;
            rounding_select_o <= round_mode_t'(next_round);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trap_o <= 1'b0;
            zero_result_o <= 1'b0;
            deliver_rounded_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else
        begin
            trap_o <= ev_valid && ev_trap;
            zero_result_o <= next_zero;
            deliver_rounded_o <= next_deliver;
            busy_o <= (next_state == ST_BUSY);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_data_o <= STATUS_RESET;
            store_valid_o <= 1'b0;
        end
        else
        begin
            store_valid_o <= store_status_i;
            if (store_status_i)
                store_data_o <= status_o;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_kind_o <= OP_NONE;
            int_bytes_o <= 3'h0;
            single_o <= 1'b0;
        end
        else if (accept)
        begin
            op_kind_o <= dec_kind;
            int_bytes_o <= dec_bytes;
            single_o <= dec_single;
        end
    end

endmodule

`default_nettype wire

// ===== fpu_status_pkg.sv
/*
 * Constants and types for the floating-point status and opcode decode
 * block: status word layout, trap cause codes, rounding codes and
 * instruction field encodings.
 * Assumes nothing; imported by every design file.
 */
package fpu_status_pkg;

    localparam int STATUS_W = 32;
    localparam int LIVE_W = 17;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_LIVE_MASK = 32'h0001_FFFF;

    // Status word field positions
    localparam int TRAP_CAUSE_LSB = 0;
    localparam int TRAP_CAUSE_W = 3;
    localparam int UNDERFLOW_EN_BIT = 3;
    localparam int UNDERFLOW_FLAG_BIT = 4;
    localparam int INEXACT_EN_BIT = 5;
    localparam int INEXACT_FLAG_BIT = 6;
    localparam int ROUND_LSB = 7;
    localparam int ROUND_W = 2;
    localparam int SOFT_LSB = 9;
    localparam int SOFT_W = 7;
    localparam int REG_WRITTEN_BIT = 16;

    // Trap cause codes; 3'h7 is never produced
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_UNDERFLOW = 3'h1;
    localparam logic [2:0] CAUSE_OVERFLOW = 3'h2;
    localparam logic [2:0] CAUSE_DIV_ZERO = 3'h3;
    localparam logic [2:0] CAUSE_ILLEGAL = 3'h4;
    localparam logic [2:0] CAUSE_INVALID = 3'h5;
    localparam logic [2:0] CAUSE_INEXACT = 3'h6;

    typedef enum logic [1:0] {
        ROUND_NEAREST = 2'h0,
        ROUND_TO_ZERO = 2'h1,
        ROUND_UP = 2'h2,
        ROUND_DOWN = 2'h3
    } round_mode_t;

    // Integer size field and precision bit
    localparam logic [1:0] ISIZE_BYTE = 2'h0;
    localparam logic [1:0] ISIZE_WORD = 2'h1;
    localparam logic [1:0] ISIZE_NARROW = 2'h2;
    localparam logic [1:0] ISIZE_DWORD = 2'h3;
    localparam logic PREC_SINGLE = 1'b1;

    typedef enum logic [1:0] {
        FMT_9 = 2'h0,
        FMT_11 = 2'h1,
        FMT_12 = 2'h2,
        FMT_NONE = 2'h3
    } fmt_t;

    // Format 9 op codes
    localparam logic [2:0] OP9_INT_TO_FLOAT = 3'h0;
    localparam logic [2:0] OP9_LOAD_STATUS = 3'h1;
    localparam logic [2:0] OP9_NARROW = 3'h2;
    localparam logic [2:0] OP9_WIDEN = 3'h3;
    localparam logic [2:0] OP9_ROUND = 3'h4;
    localparam logic [2:0] OP9_CHOP = 3'h5;
    localparam logic [2:0] OP9_STORE_STATUS = 3'h6;
    localparam logic [2:0] OP9_FLOOR = 3'h7;
    // Format 11 op codes
    localparam logic [3:0] OP11_ADD = 4'h0;
    localparam logic [3:0] OP11_MOVE = 4'h1;
    localparam logic [3:0] OP11_COMPARE = 4'h2;
    localparam logic [3:0] OP11_SUB = 4'h4;
    localparam logic [3:0] OP11_NEG = 4'h5;
    localparam logic [3:0] OP11_DIV = 4'h8;
    localparam logic [3:0] OP11_MUL = 4'hC;
    localparam logic [3:0] OP11_ABS = 4'hD;
    // Format 12 op codes
    localparam logic [3:0] OP12_POLY = 4'h2;
    localparam logic [3:0] OP12_DOT = 4'h3;
    localparam logic [3:0] OP12_SCALE = 4'h4;
    localparam logic [3:0] OP12_EXTRACT = 4'h5;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_INT_TO_FLOAT = 5'h01,
        OP_LOAD_STATUS = 5'h02,
        OP_NARROW_MOVE = 5'h03,
        OP_WIDEN_MOVE = 5'h04,
        OP_ROUND_TO_INT = 5'h05,
        OP_CHOP_TO_INT = 5'h06,
        OP_STORE_STATUS = 5'h07,
        OP_FLOOR_TO_INT = 5'h08,
        OP_ADD = 5'h09,
        OP_MOVE_FLOAT = 5'h0A,
        OP_COMPARE = 5'h0B,
        OP_SUBTRACT = 5'h0C,
        OP_NEGATE = 5'h0D,
        OP_DIVIDE = 5'h0E,
        OP_MULTIPLY = 5'h0F,
        OP_ABSOLUTE = 5'h10,
        OP_POLY = 5'h11,
        OP_DOT = 5'h12,
        OP_EXP_SCALE = 5'h13,
        OP_EXP_EXTRACT = 5'h14
    } op_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } ctl_state_t;

endpackage

// ===== fpu_opcode_decoder.sv
/*
 * Combinational decoder for the format 9, 11 and 12 op fields, the
 * integer size field and the precision bit.
 * Assumes the fields are stable while the caller samples the result.
 */
`timescale 1ns/1ps
`default_nettype none

module fpu_opcode_decoder
(
    input wire logic [1:0] format_i,
    input wire logic [3:0] op_i,
    input wire logic [1:0] int_size_i,
    input wire logic precision_i,
    output fpu_status_pkg::op_kind_t op_kind_o,
    output logic [2:0] int_bytes_o,
    output logic single_o,
    output logic illegal_o
);
    import fpu_status_pkg::*;

    function automatic op_kind_t decode_op(input logic [1:0] fmt,
                                           input logic [3:0] op);
        op_kind_t k;
        k = OP_NONE;
        if (fmt == FMT_9 && op[3] == 1'b0)
        begin
            case (op[2:0])
                OP9_INT_TO_FLOAT: k = OP_INT_TO_FLOAT;
                OP9_LOAD_STATUS: k = OP_LOAD_STATUS;
                OP9_NARROW: k = OP_NARROW_MOVE;
                OP9_WIDEN: k = OP_WIDEN_MOVE;
                OP9_ROUND: k = OP_ROUND_TO_INT;
                OP9_CHOP: k = OP_CHOP_TO_INT;
                OP9_STORE_STATUS: k = OP_STORE_STATUS;
                default: k = OP_FLOOR_TO_INT;
            endcase
        end
        else if (fmt == FMT_11)
        begin
            case (op)
                OP11_ADD: k = OP_ADD;
                OP11_MOVE: k = OP_MOVE_FLOAT;
                OP11_COMPARE: k = OP_COMPARE;
                OP11_SUB: k = OP_SUBTRACT;
                OP11_NEG: k = OP_NEGATE;
                OP11_DIV: k = OP_DIVIDE;
                OP11_MUL: k = OP_MULTIPLY;
                OP11_ABS: k = OP_ABSOLUTE;
                default: k = OP_NONE;
            endcase
        end
        else if (fmt == FMT_12)
        begin
            case (op)
                OP12_POLY: k = OP_POLY;
                OP12_DOT: k = OP_DOT;
                OP12_SCALE: k = OP_EXP_SCALE;
                OP12_EXTRACT: k = OP_EXP_EXTRACT;
                default: k = OP_NONE;
            endcase
        end
        return k;
    endfunction

    wire op_kind_t kind = decode_op(format_i, op_i);
    wire uses_isize = (kind == OP_INT_TO_FLOAT) || (kind == OP_ROUND_TO_INT)
        || (kind == OP_CHOP_TO_INT) || (kind == OP_FLOOR_TO_INT);
    wire bad_isize = uses_isize && (int_size_i == ISIZE_NARROW);
    wire bad_narrow = (kind == OP_NARROW_MOVE)
        && !(precision_i == PREC_SINGLE && int_size_i == ISIZE_NARROW);
    wire bad_widen = (kind == OP_WIDEN_MOVE)
        && !(precision_i != PREC_SINGLE && int_size_i == ISIZE_DWORD);

    assign op_kind_o = kind;
    assign illegal_o = (kind == OP_NONE) || bad_isize || bad_narrow
        || bad_widen;
    assign single_o = (precision_i == PREC_SINGLE);
    assign int_bytes_o = (int_size_i == ISIZE_BYTE) ? 3'h1 :
                         (int_size_i == ISIZE_WORD) ? 3'h2 :
                         (int_size_i == ISIZE_DWORD) ? 3'h4 : 3'h0;

endmodule

`default_nettype wire

// ===== fpu_trap_cause_encoder.sv
/*
 * Priority encoder for one instruction's exception conditions into a
 * trap cause code, plus the trap request decision.
 * Assumes condition inputs are qualified by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module fpu_trap_cause_encoder
(
    input wire logic illegal_i,
    input wire logic invalid_i,
    input wire logic div_zero_i,
    input wire logic overflow_i,
    input wire logic underflow_i,
    input wire logic inexact_i,
    input wire logic underflow_en_i,
    input wire logic inexact_en_i,
    output logic [2:0] cause_o,
    output logic other_error_o,
    output logic trap_o
);
    import fpu_status_pkg::*;

    wire hard_error = illegal_i || invalid_i || div_zero_i || overflow_i;

    // Inexact only shows when nothing else went wrong
    assign other_error_o = hard_error || underflow_i;
    assign cause_o = illegal_i ? CAUSE_ILLEGAL :
                     invalid_i ? CAUSE_INVALID :
                     div_zero_i ? CAUSE_DIV_ZERO :
                     overflow_i ? CAUSE_OVERFLOW :
                     underflow_i ? CAUSE_UNDERFLOW :
                     inexact_i ? CAUSE_INEXACT : CAUSE_NONE;
    assign trap_o = hard_error
        || (underflow_i && underflow_en_i)
        || (inexact_i && !other_error_o && inexact_en_i);

endmodule

`default_nettype wire

// ===== fpu_status_and_opcode_decode_properties.sv
/* Port checks for the status and decode block.
   Bound to the top module; all on mclk_i. */
`timescale 1ns/1ps
`default_nettype none

module fpu_status_checker
    import fpu_status_pkg::*;
(
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic instr_valid_i,
    input wire logic [1:0] format_i,
    input wire logic done_i,
    input wire logic underflow_i,
    input wire logic overflow_i,
    input wire logic div_by_zero_i,
    input wire logic reserved_operand_i,
    input wire logic zero_by_zero_i,
    input wire logic inexact_i,
    input wire logic load_status_i,
    input wire logic [31:0] load_data_i,
    input wire logic [31:0] status_o,
    input wire fpu_status_pkg::round_mode_t rounding_select_o,
    input wire logic trap_o,
    input wire logic zero_result_o,
    input wire logic busy_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Errors that outrank underflow and inexact
    wire logic hi_err = overflow_i || reserved_operand_i || zero_by_zero_i
        || div_by_zero_i;

    sequence s_finish;
        busy_o && done_i && !load_status_i;
    endsequence
    sequence s_accept;
        instr_valid_i && !busy_o && !load_status_i;
    endsequence

    a_upper_zero: assert property (status_o[31:17] == 15'h0)
        else $error("upper status bits set");
    a_cause_legal: assert property (status_o[2:0] != 3'h7)
        else $error("reserved cause code");
    a_round_copy: assert property (rounding_select_o == status_o[8:7])
        else $error("rounding select mismatch");
    a_load_word: assert property (load_status_i && !busy_o
        && !instr_valid_i |=> status_o == ($past(load_data_i)
        & STATUS_LIVE_MASK))
        else $error("load not applied");
    a_underflow_rec: assert property (s_finish ##0 underflow_i
        && !hi_err |=> status_o[2:0] == CAUSE_UNDERFLOW && status_o[4]
        && trap_o == $past(status_o[3])
        && zero_result_o != $past(status_o[3]))
        else $error("underflow not recorded");
    a_inexact_rec: assert property (s_finish ##0 inexact_i
        && !underflow_i && !hi_err |=> status_o[2:0] == CAUSE_INEXACT
        && status_o[6] && trap_o == $past(status_o[5]))
        else $error("inexact not recorded");
    a_overflow_trap: assert property (s_finish ##0 overflow_i
        && !reserved_operand_i && !zero_by_zero_i && !div_by_zero_i
        |=> status_o[2:0] == CAUSE_OVERFLOW && trap_o)
        else $error("overflow not trapped");
    a_inexact_kept: assert property (s_finish ##0 inexact_i
        && (overflow_i || underflow_i || reserved_operand_i)
        |=> status_o[6] == $past(status_o[6])
        && status_o[2:0] != CAUSE_INEXACT)
        else $error("inexact flag altered");
    a_illegal_fmt: assert property (s_accept ##0 format_i == 2'h3
        |=> trap_o && status_o[2:0] == CAUSE_ILLEGAL && !busy_o)
        else $error("illegal not reported");
    a_busy_done: assert property (busy_o |=> busy_o == !$past(done_i))
        else $error("busy vs done");
    a_under_sticky: assert property (status_o[4] && !load_status_i
        |=> status_o[4])
        else $error("underflow flag dropped");
endmodule

bind fpu_status_and_opcode_decode fpu_status_checker u_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
    .format_i(format_i), .done_i(done_i), .underflow_i(underflow_i),
    .overflow_i(overflow_i), .div_by_zero_i(div_by_zero_i),
    .reserved_operand_i(reserved_operand_i),
    .zero_by_zero_i(zero_by_zero_i), .inexact_i(inexact_i),
    .load_status_i(load_status_i), .load_data_i(load_data_i),
    .status_o(status_o), .rounding_select_o(rounding_select_o),
    .trap_o(trap_o), .zero_result_o(zero_result_o), .busy_o(busy_o)
);
`default_nettype wire

// ===== fpu_datapath_model.sv
/* Datapath model: one done pulse per busy period, lat_i cycles in.
   Assumes busy_i is the busy output; drives on falling edges. */
`timescale 1ns/1ps
`default_nettype none

module fpu_datapath_model
(
    input wire logic mclk_i,
    input wire logic busy_i,
    input wire logic [2:0] lat_i,
    input wire logic [6:0] cond_i,
    output logic done_o,
    output logic [6:0] cond_o
);
    logic [2:0] cnt = 3'h0;
    logic fired = 1'b0;

    initial
    begin
        done_o = 1'b0;
        cond_o = 7'h55;
    end

    // Toggle conditions off the done cycle
    always @(negedge mclk_i)
    begin
        if (busy_i && !fired && cnt == lat_i)
        begin
            done_o <= 1'b1;
            cond_o <= cond_i;
            fired <= 1'b1;
        end
        else
        begin
            done_o <= 1'b0;
            cond_o <= ~cond_o;
            cnt <= busy_i ? cnt + 3'h1 : 3'h0;
            fired <= fired && busy_i;
        end
    end
endmodule
`default_nettype wire

// ===== test_fpu_status_and_opcode_decode.sv
/* Bench for the status and decode block; needs checker and model. */
`timescale 1ns/1ps
`default_nettype none

module test_fpu_status_and_opcode_decode;
    import fpu_status_pkg::*;

    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [1:0] format_i = 2'h0;
    logic [3:0] op_i = 4'h0;
    logic [1:0] int_size_i = 2'h0;
    logic precision_i = 1'b0;
    logic load_status_i = 1'b0;
    logic [31:0] load_data_i = 32'h0;
    logic store_status_i = 1'b0;
    logic [2:0] lat = 3'h0;
    logic [6:0] cond = 7'h0, dp_c;
    logic [31:0] status_o, store_data_o;
    logic store_valid_o, trap_o, zero_result_o, deliver_rounded_o;
    logic single_o, busy_o, done_i;
    logic [2:0] int_bytes_o;
    round_mode_t rounding_select_o;
    op_kind_t op_kind_o;
    logic [31:0] rnd = 32'h2AAE;
    logic [31:0] exp_st = 32'h0;
    int error_cnt = 0, checks_done = 0;
    op_kind_t t9[8] = '{OP_INT_TO_FLOAT, OP_LOAD_STATUS, OP_NARROW_MOVE,
        OP_WIDEN_MOVE, OP_ROUND_TO_INT, OP_CHOP_TO_INT, OP_STORE_STATUS,
        OP_FLOOR_TO_INT};
    op_kind_t t11[16] = '{0: OP_ADD, 1: OP_MOVE_FLOAT, 2: OP_COMPARE,
        4: OP_SUBTRACT, 5: OP_NEGATE, 8: OP_DIVIDE, 12: OP_MULTIPLY,
        13: OP_ABSOLUTE, default: OP_NONE};
    op_kind_t t12[16] = '{2: OP_POLY, 3: OP_DOT, 4: OP_EXP_SCALE,
        5: OP_EXP_EXTRACT, default: OP_NONE};
    // Directed cases: enables, divide select, conditions
    logic [9:0] cases[11] = '{10'h040, 10'h001, 10'h201, 10'h020, 10'h120,
        10'h022, 10'h084, 10'h004, 10'h094, 10'h008, 10'h021};

    always #50 mclk_i = ~mclk_i;

    fpu_status_and_opcode_decode u_dut (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
        .format_i(format_i), .op_i(op_i), .int_size_i(int_size_i),
        .precision_i(precision_i), .done_i(done_i),
        .underflow_i(dp_c[0]), .overflow_i(dp_c[1]), .div_by_zero_i(dp_c[2]),
        .reserved_operand_i(dp_c[3]), .zero_by_zero_i(dp_c[4]),
        .inexact_i(dp_c[5]), .reg_write_i(dp_c[6]),
        .load_status_i(load_status_i), .load_data_i(load_data_i),
        .store_status_i(store_status_i), .status_o(status_o),
        .store_data_o(store_data_o), .store_valid_o(store_valid_o),
        .rounding_select_o(rounding_select_o), .trap_o(trap_o),
        .zero_result_o(zero_result_o),
        .deliver_rounded_o(deliver_rounded_o), .op_kind_o(op_kind_o),
        .int_bytes_o(int_bytes_o), .single_o(single_o), .busy_o(busy_o)
    );
    fpu_datapath_model u_dp (
        .mclk_i(mclk_i), .busy_i(busy_o), .lat_i(lat), .cond_i(cond),
        .done_o(done_i), .cond_o(dp_c)
    );

    function automatic logic [31:0] load_status_cmd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic load(input logic [31:0] v);
        @(negedge mclk_i);
        load_status_i = 1'b1;
        load_data_i = v;
        @(negedge mclk_i);
        load_status_i = 1'b0;
        load_data_i = ~v;
        exp_st = v & STATUS_LIVE_MASK;
        cmp(status_o, exp_st);
        cmp(rounding_select_o, v[8:7]);
    endtask

    task automatic store;
        @(negedge mclk_i);
        store_status_i = 1'b1;
        @(negedge mclk_i);
        store_status_i = 1'b0;
        cmp({store_valid_o, store_data_o}, {1'b1, exp_st});
    endtask

    task automatic run(input logic [1:0] f, input logic [3:0] o,
        input logic [1:0] s, input logic p, input logic [6:0] c);
        op_kind_t k;
        logic bad, inv, dz, oth, tr, zr;
        logic [2:0] cs;
        int n;
        k = f == 2'h0 ? (o[3] ? OP_NONE : t9[o[2:0]]) : f == 2'h1 ? t11[o]
            : f == 2'h2 ? t12[o] : OP_NONE;
        bad = k == OP_NONE || (k == OP_NARROW_MOVE && !(p && s == 2'h2))
            || (k == OP_WIDEN_MOVE && !(!p && s == 2'h3)) || (s == 2'h2
            && k inside {OP_INT_TO_FLOAT, OP_ROUND_TO_INT, OP_CHOP_TO_INT,
            OP_FLOOR_TO_INT});
        rnd = load_status_cmd(rnd);
        @(negedge mclk_i);
        instr_valid_i = 1'b1;
        format_i = f;
        op_i = o;
        int_size_i = s;
        precision_i = p;
        cond = c;
        lat = rnd[2:0];
        @(negedge mclk_i);
        instr_valid_i = 1'b0;
        if (bad)
        begin
            exp_st[2:0] = CAUSE_ILLEGAL;
            cmp({trap_o, busy_o}, 2'h2);
        end
        else
        begin
            cmp({op_kind_o, single_o}, {k, p});
            cmp(int_bytes_o, s == 2'h0 ? 3'h1 : s == 2'h1 ? 3'h2
                : s == 2'h3 ? 3'h4 : 3'h0);
        end
        if (!bad && k != OP_LOAD_STATUS && k != OP_STORE_STATUS)
        begin
            n = 0;
            do
            begin
                @(posedge mclk_i);
                n++;
            end
            while (!done_i && n < 20);
            if (!done_i)
            begin
                error_cnt++;
                finish_test();
            end
            @(negedge mclk_i);
            inv = c[3] || (k == OP_DIVIDE && c[4]);
            dz = k == OP_DIVIDE && c[2] && !c[4];
            oth = inv || dz || c[1] || c[0];
            cs = inv ? CAUSE_INVALID : dz ? CAUSE_DIV_ZERO : c[1]
                ? CAUSE_OVERFLOW : c[0] ? CAUSE_UNDERFLOW : c[5]
                ? CAUSE_INEXACT : CAUSE_NONE;
            zr = cs == CAUSE_UNDERFLOW && !exp_st[3];
            tr = oth && !zr || (c[5] && !oth && exp_st[5]);
            cmp({trap_o, busy_o}, {tr, 1'b0});
            cmp({zero_result_o, deliver_rounded_o},
                {zr, cs == CAUSE_INEXACT && !exp_st[5]});
            exp_st[2:0] = cs;
            exp_st[4] = exp_st[4] | c[0];
            exp_st[6] = exp_st[6] | (c[5] && !oth);
            exp_st[16] = exp_st[16] | (c[6] && !tr);
        end
        cmp(status_o, exp_st);
    endtask

    initial
    begin
        logic [1:0] s;
        logic p;
        logic [6:0] rc;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        cmp({status_o, op_kind_o, busy_o}, {32'h0, OP_NONE, 1'b0});
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            rnd = load_status_cmd(rnd);
            load({rnd[31:9], i[1:0], rnd[6:2], 1'b0, rnd[0]});
            store();
        end
        load(32'h0);
        $display("load and store test done");
        for (int j = 0; j < 128; j++)
        begin
            rnd = load_status_cmd(rnd);
            s = rnd[4:3];
            p = rnd[5];
            if (!j[6] && j[5:1] == 5'h01)
            begin
                s = {1'b1, j[0]};
                p = !j[0];
            end
            run(j[5:4], j[3:0], s, p, 7'h0);
        end
        $display("decode test done");
        foreach (cases[i])
        begin
            load({26'h0, cases[i][8], 1'b0, cases[i][9], 3'h0});
            run(2'h1, cases[i][7] ? OP11_DIV : OP11_ADD, 2'h0, 1'b1,
                cases[i][6:0]);
        end
        $display("exception test done");
        for (int i = 0; i < 48; i++)
        begin
            rnd = load_status_cmd(rnd);
            if (i % 4 == 0)
                load({rnd[31:3], 3'h0});
            rnd = load_status_cmd(rnd);
            rc = rnd[22:16] & rnd[14:8];
            rc = rc & {2'h3, {4{~rc[0]}}, 1'b1};
            run(2'h1, rnd[9] ? OP11_DIV : OP11_ADD, 2'h0, rnd[10], rc);
        end
        $display("random test done");
        finish_test();
    end
endmodule
`default_nettype wire
